/* File: logic/part_pkg.sv */
// Offsets, field positions and fixed read values of the PMA role and test registers
package part_pkg;
  // Device address these registers live under
  localparam logic [4:0]  PMA_DEVAD          = 5'h01;
  // Register offsets within the device space
  localparam logic [15:0] OFS_EXT_ABILITY2   = 16'h0012;
  localparam logic [15:0] OFS_ROLE_CTRL      = 16'h0834;
  localparam logic [15:0] OFS_TEST_CTRL      = 16'h0836;
  // Fixed read values
  localparam logic [15:0] EXT_ABILITY2_VAL   = 16'h0001;
  localparam logic [15:0] ROLE_CTRL_FIXED    = 16'h8000;
  // Field positions
  localparam int          ROLE_BIT           = 14;
  localparam int          TEST_LSB           = 4;
  localparam int          TEST_W             = 3;
  // Strap sampling delay after reset release, in clock cycles
  localparam logic [1:0]  STRAP_WAIT         = 2'h3;
  // Test mode codes
  typedef enum logic [2:0]
  {
    TM_NORMAL = 3'h0,
    TM_MODE1  = 3'h1,
    TM_MODE2  = 3'h2,
    TM_MODE4  = 3'h4,
    TM_MODE5  = 3'h5
  } part_test_e;
endpackage

/* File: logic/part_pma_regs.sv */
// PMA ability, link role and compliance test registers of the PHY
//
// Operation
// R1: Extended ability register two reads 0x0001, bit 0 reporting support.
// R2: Bit 14 of the role control register selects master (1) or slave (0).
// R3: The role bit resets from its strap; bit 15 reads 1, bits 13:0 read 0.
// R4: Test field codes select normal, mode 1, 2, 4 or 5; others undefined.
// R5: Test field is read-write with a strap reset; bits 3:0 read 0.
// R6: The host reaches these registers with device address 1.
// R7: Writes to reserved or read-only bits are ignored and reads stay fixed.
module part_pma_regs
  import part_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // Bootstrap pins
  input  wire logic        strapMaster,
  input  wire logic [2:0]  strapTestMode,
  // Management access from the serial interface decoder
  input  wire logic        mgmtWrEn,
  input  wire logic        mgmtRdEn,
  input  wire logic [4:0]  mgmtDevAd,
  input  wire logic [15:0] mgmtAddr,
  input  wire logic [15:0] mgmtWrData,
  output logic      [15:0] mgmtRdData,
  output logic             mgmtRdHit,
  // Mode outputs to the PHY core
  output logic             roleMaster,
  output logic      [2:0]  testMode,
  output logic             testActive
);

  // Straps are pins: two-stage synchronisers
  logic        strapMasterS1_ff;
  logic        strapMasterS2_ff;
  logic [2:0]  strapTestS1_ff;
  logic [2:0]  strapTestS2_ff;
  // Straps latch once, a few cycles after reset release
  logic [1:0]  loadCnt_ff;
  logic        loaded_ff;
  logic        roleMaster_ff;
  logic [2:0]  testMode_ff;
  logic [15:0] rdData_ff;
  logic        rdHit_ff;
  // Saturating count from reset release, read only by the checks below
  logic [2:0]  relCnt_ff;

  wire logic devHit     = (mgmtDevAd == PMA_DEVAD); // R6
  wire logic selAbility = devHit && (mgmtAddr == OFS_EXT_ABILITY2);
  wire logic selRole    = devHit && (mgmtAddr == OFS_ROLE_CTRL);
  wire logic selTest    = devHit && (mgmtAddr == OFS_TEST_CTRL);
  wire logic anySel     = selAbility | selRole | selTest;
  wire logic strapLoad  = !loaded_ff && (loadCnt_ff == STRAP_WAIT);
  wire logic [2:0] nxt_relCnt = (relCnt_ff == 3'h7) ? relCnt_ff
                              : relCnt_ff + 3'h1;

  // Only the writable fields are taken; the rest of the word is dropped
  wire logic       nxt_roleMaster = strapLoad ? strapMasterS2_ff
                                  : (mgmtWrEn && selRole)
                                  ? mgmtWrData[ROLE_BIT]
                                  : roleMaster_ff; // R2 R3 R7
  wire logic [2:0] nxt_testMode   = strapLoad ? strapTestS2_ff
                                  : (mgmtWrEn && selTest)
                                  ? mgmtWrData[TEST_LSB +: TEST_W]
                                  : testMode_ff; // R5 R7

  wire logic [15:0] roleWord = ROLE_CTRL_FIXED
                             | (16'(roleMaster_ff) << ROLE_BIT); // R3
  wire logic [15:0] testWord = 16'(testMode_ff) << TEST_LSB; // R5
  wire logic [15:0] nxt_rdData = selAbility ? EXT_ABILITY2_VAL // R1
                               : selRole    ? roleWord
                               : selTest    ? testWord
                               : 16'h0000;

  always_ff @(posedge ref_clk)
  begin
    strapMasterS1_ff <= strapMaster;
    strapMasterS2_ff <= strapMasterS1_ff;
    strapTestS1_ff   <= strapTestMode;
    strapTestS2_ff   <= strapTestS1_ff;
  end

  // Checking aid only; saturates so it never wraps into a false hit
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      relCnt_ff <= 3'h0;
    else
      relCnt_ff <= nxt_relCnt;
  end

  // Wait for the synchronisers to settle before sampling straps
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      loadCnt_ff <= 2'h0;
      loaded_ff  <= 1'b0;
    end
    else if (!loaded_ff)
    begin
      loadCnt_ff <= loadCnt_ff + 2'h1;
      loaded_ff  <= strapLoad;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      roleMaster_ff <= 1'b0;
      testMode_ff   <= TM_NORMAL;
      rdData_ff     <= 16'h0000;
      rdHit_ff      <= 1'b0;
    end
    else
    begin
      roleMaster_ff <= nxt_roleMaster;
      testMode_ff   <= nxt_testMode;
      rdData_ff     <= mgmtRdEn ? nxt_rdData : rdData_ff;
      rdHit_ff      <= mgmtRdEn && anySel;
    end
  end

  assign mgmtRdData = rdData_ff;
  assign mgmtRdHit  = rdHit_ff;
  assign roleMaster = roleMaster_ff; // R2
  assign testMode   = testMode_ff; // R4
  // Undefined codes are treated as a test mode, never as normal traffic
  assign testActive = (testMode_ff != TM_NORMAL); // R4

  // Ability register
  a_ability_fixed: assert property (@(posedge ref_clk) // R1
    disable iff (!rstn)
    mgmtRdEn && selAbility |=> mgmtRdData == 16'h0001 && mgmtRdHit)
    else $error("ability register read wrong");
  a_ability_wr: assert property (@(posedge ref_clk) disable iff (!rstn) // R1
    loaded_ff && mgmtWrEn && selAbility
      |=> $stable(roleMaster) && $stable(testMode))
    else $error("ability write changed a mode");

  // Link role
  a_role_write: assert property (@(posedge ref_clk) disable iff (!rstn) // R2
    loaded_ff && mgmtWrEn && selRole |=> roleMaster == $past(mgmtWrData[14]))
    else $error("role bit not written");
  a_role_read: assert property (@(posedge ref_clk) disable iff (!rstn) // R2
    mgmtRdEn && selRole |=> mgmtRdData[14] == $past(roleMaster))
    else $error("role bit read wrong");
  a_role_word: assert property (@(posedge ref_clk) disable iff (!rstn) // R3
    mgmtRdEn && selRole |=> mgmtRdData[15] && mgmtRdData[13:0] == 14'h0)
    else $error("role register fixed bits wrong");
  a_role_strap: assert property (@(posedge ref_clk) disable iff (!rstn) // R3
    strapLoad |=> roleMaster == $past(strapMasterS2_ff))
    else $error("role strap not loaded");

  // Reset and strap timing
  a_reset_clear: assert property (@(posedge ref_clk) // R3
    !rstn |=> !roleMaster && testMode == 3'h0
      && !mgmtRdHit && mgmtRdData == 16'h0000)
    else $error("reset left an output set");
  a_strap_time: assert property (@(posedge ref_clk) disable iff (!rstn) // R3
    strapLoad |-> relCnt_ff == 3'h3)
    else $error("straps sampled at the wrong cycle");
  a_strap_late: assert property (@(posedge ref_clk) disable iff (!rstn) // R3
    relCnt_ff == 3'h4 |-> loaded_ff)
    else $error("straps never sampled");
  a_load_once: assert property (@(posedge ref_clk) disable iff (!rstn) // R3
    loaded_ff |=> loaded_ff)
    else $error("strap load repeated");

  // Test field
  a_test_active: assert property (@(posedge ref_clk) disable iff (!rstn) // R4
    testActive == (testMode != 3'h0))
    else $error("test active flag wrong");
  a_test_flag: assert property (@(posedge ref_clk) disable iff (!rstn) // R4
    loaded_ff && mgmtRdEn && selTest && !mgmtWrEn
      |=> testActive == (mgmtRdData[6:4] != 3'h0))
    else $error("test active flag disagrees with read");
  a_undef_active: assert property (@(posedge ref_clk) disable iff (!rstn) // R4
    loaded_ff && mgmtWrEn && selTest && mgmtWrData[6:4] == 3'h7
      |=> testActive)
    else $error("undefined test code left inactive");
  a_normal_idle: assert property (@(posedge ref_clk) disable iff (!rstn) // R4
    loaded_ff && mgmtWrEn && selTest && mgmtWrData[6:4] == 3'h0
      |=> !testActive)
    else $error("normal code left a test active");
  a_test_word: assert property (@(posedge ref_clk) disable iff (!rstn) // R5
    mgmtRdEn && selTest |=> mgmtRdData[3:0] == 4'h0
      && mgmtRdData[15:7] == 9'h0 && mgmtRdData[6:4] == $past(testMode))
    else $error("test register read wrong");
  a_test_write: assert property (@(posedge ref_clk) disable iff (!rstn) // R5
    loaded_ff && mgmtWrEn && selTest |=> testMode == $past(mgmtWrData[6:4]))
    else $error("test field not written");
  a_test_strap: assert property (@(posedge ref_clk) disable iff (!rstn) // R5
    strapLoad |=> testMode == $past(strapTestS2_ff))
    else $error("test strap not loaded");

  // Decode and read answer
  a_wrong_devad: assert property (@(posedge ref_clk) disable iff (!rstn) // R6
    mgmtRdEn && !devHit |=> !mgmtRdHit && mgmtRdData == 16'h0)
    else $error("other device space answered");
  a_hit_valid: assert property (@(posedge ref_clk) disable iff (!rstn) // R6
    mgmtRdEn && anySel |=> mgmtRdHit)
    else $error("register read not acknowledged");
  a_hit_cause: assert property (@(posedge ref_clk) disable iff (!rstn) // R6
    mgmtRdHit |-> $past(mgmtRdEn))
    else $error("read acknowledged without a read");
  a_wrong_addr: assert property (@(posedge ref_clk) disable iff (!rstn) // R7
    mgmtRdEn && devHit && !anySel |=> !mgmtRdHit && mgmtRdData == 16'h0000)
    else $error("unmapped address answered");

  // Nothing moves without its own write, and read data not without a read
  a_role_hold: assert property (@(posedge ref_clk) disable iff (!rstn) // R7
    loaded_ff && !(mgmtWrEn && selRole) |=> $stable(roleMaster))
    else $error("role bit changed without write");
  a_test_hold: assert property (@(posedge ref_clk) disable iff (!rstn) // R7
    loaded_ff && !(mgmtWrEn && selTest) |=> $stable(testMode))
    else $error("test field changed without write");
  a_cross_write: assert property (@(posedge ref_clk) disable iff (!rstn) // R7
    loaded_ff && mgmtWrEn && selRole |=> $stable(testMode))
    else $error("role write changed the test field");
  a_rd_no_state: assert property (@(posedge ref_clk) disable iff (!rstn) // R7
    loaded_ff && mgmtRdEn && !mgmtWrEn
      |=> $stable(roleMaster) && $stable(testMode))
    else $error("read changed a mode");
  a_rdata_hold: assert property (@(posedge ref_clk) disable iff (!rstn) // R7
    !mgmtRdEn |=> $stable(mgmtRdData))
    else $error("read data changed without a read");
  a_wr_quiet: assert property (@(posedge ref_clk) disable iff (!rstn) // R7
    mgmtWrEn && !mgmtRdEn |=> !mgmtRdHit)
    else $error("write acknowledged as a read");
endmodule

/* File: tb/part_mgmt_host.sv */
// Management host model issuing single register accesses
module part_mgmt_host
  import part_pkg::*;
(
  // Clock, access strobes and the read answer
  input  wire logic        ref_clk,
  output logic             mgmtWrEn,
  output logic             mgmtRdEn,
  output logic      [4:0]  mgmtDevAd,
  output logic      [15:0] mgmtAddr,
  output logic      [15:0] mgmtWrData,
  input  wire logic [15:0] mgmtRdData,
  input  wire logic        mgmtRdHit
);
  timeunit 1ns / 1ns;
  initial {mgmtWrEn, mgmtRdEn, mgmtDevAd, mgmtAddr, mgmtWrData} = '0;
  // Released address, device and data lines show inverted values; both strobes drop to 0
  task automatic access(input logic wr, input logic [4:0] dv,
                        input logic [15:0] a, d,
                        output logic [15:0] q, output logic hit);
    @(negedge ref_clk);
    {mgmtWrEn, mgmtRdEn} = {wr, !wr};
    {mgmtDevAd, mgmtAddr, mgmtWrData} = {dv, a, d};
    @(negedge ref_clk);
    {mgmtWrEn, mgmtRdEn} = 2'b00;
    {mgmtDevAd, mgmtAddr, mgmtWrData} = {~dv, ~a, ~d};
    {q, hit} = {mgmtRdData, mgmtRdHit};
  endtask
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the PMA role and test registers
module tb_top;
  timeunit 1ns / 1ns;
  import part_pkg::*;
  typedef struct packed {logic w; logic [15:0] a, v;} part_row_s;
  localparam logic [15:0] EA = OFS_EXT_ABILITY2, RC = OFS_ROLE_CTRL;
  localparam logic [15:0] TC = OFS_TEST_CTRL;
  localparam logic        RD = 1'b0, WR = 1'b1;
  logic        ref_clk = 1'b0, rstn, strapMaster, hit;
  logic        mgmtWrEn, mgmtRdEn, mgmtRdHit, roleMaster, testActive;
  logic [2:0]  strapTestMode, testMode;
  logic [4:0]  mgmtDevAd;
  logic [15:0] mgmtAddr, mgmtWrData, mgmtRdData, q;
  int          err_count = 0, n_compared = 0;
  part_row_s   rows [20] = '{
    '{RD,RC,16'hC000}, '{RD,TC,16'h0050}, '{RD,EA,16'h0001},
    '{WR,EA,16'hFFFF}, '{RD,EA,16'h0001}, '{WR,RC,16'hBFFF},
    '{RD,RC,16'h8000}, '{WR,RC,16'hFFFF}, '{RD,RC,16'hC000},
    '{WR,TC,16'h0010}, '{RD,TC,16'h0010}, '{WR,TC,16'h0020},
    '{RD,TC,16'h0020}, '{WR,TC,16'h0040}, '{RD,TC,16'h0040},
    '{WR,TC,16'hFFFF}, '{RD,TC,16'h0070}, '{WR,TC,16'h0000},
    '{RD,TC,16'h0000}, '{RD,16'h0835,16'h0000}};
  part_pma_regs part_pma_regs_i (
    .ref_clk       (ref_clk),
    .rstn          (rstn),
    .strapMaster   (strapMaster),
    .strapTestMode (strapTestMode),
    .mgmtWrEn      (mgmtWrEn),
    .mgmtRdEn      (mgmtRdEn),
    .mgmtDevAd     (mgmtDevAd),
    .mgmtAddr      (mgmtAddr),
    .mgmtWrData    (mgmtWrData),
    .mgmtRdData    (mgmtRdData),
    .mgmtRdHit     (mgmtRdHit),
    .roleMaster    (roleMaster),
    .testMode      (testMode),
    .testActive    (testActive)
  );
  part_mgmt_host part_mgmt_host_i (
    .ref_clk    (ref_clk),
    .mgmtWrEn   (mgmtWrEn),
    .mgmtRdEn   (mgmtRdEn),
    .mgmtDevAd  (mgmtDevAd),
    .mgmtAddr   (mgmtAddr),
    .mgmtWrData (mgmtWrData),
    .mgmtRdData (mgmtRdData),
    .mgmtRdHit  (mgmtRdHit)
  );
  initial forever #25 ref_clk = ~ref_clk;
  task automatic check(input string nm, input logic [16:0] seen, exp);
    n_compared++;
    err_count += int'(seen !== exp);
    if (seen !== exp)
      $display("FAIL %s exp %h seen %h", nm, exp, seen);
  endtask
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    #50us;
    err_count++;
    summarize();
  end
  initial
  begin
    {rstn, strapMaster, strapTestMode} = 5'b0_1_101;
    repeat (5) @(negedge ref_clk);
    rstn = 1'b1;
    repeat (6) @(negedge ref_clk);
    check("strap", 17'({roleMaster, testActive, testMode}), 17'h1D);
    foreach (rows[i])
    begin
      part_mgmt_host_i.access(rows[i].w, PMA_DEVAD, rows[i].a, rows[i].v,
                              q, hit);
      if (!rows[i].w)
        check("read", {q, hit},
              {rows[i].v, rows[i].a != 16'h0835});
    end
    // Another device space must neither answer nor take a write
    part_mgmt_host_i.access(WR, 5'h02, RC, 16'h0000, q, hit);
    part_mgmt_host_i.access(RD, 5'h02, RC, 16'h0000, q, hit);
    check("devad read", {q, hit}, 17'h00000);
    part_mgmt_host_i.access(RD, PMA_DEVAD, RC, 16'h0000, q, hit);
    check("devad write", {q, hit}, {16'hC000, 1'b1});
    check("modes", 17'({roleMaster, testActive, testMode}), 17'h10);
    // Reset in mid-run with other strap levels
    {rstn, strapMaster, strapTestMode} = 5'b0_0_010;
    repeat (5) @(negedge ref_clk);
    check("reset data", {mgmtRdData, mgmtRdHit}, 17'h00000);
    check("reset modes", 17'({roleMaster, testActive, testMode}), 17'h0);
    rstn = 1'b1;
    repeat (6) @(negedge ref_clk);
    check("restrap", 17'({roleMaster, testActive, testMode}), 17'h0A);
    summarize();
  end
endmodule
